// ---- hdl/fc_pkg.sv ----
// Package with register indices, reset values and state types of the frame checker counters.
package fc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_ENABLE = 16'h8001;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'h8004;
  localparam logic [15:0] IDX_PATH_SELECT = 16'h8005;
  localparam logic [15:0] IDX_ERR_COUNT = 16'h8008;
  localparam logic [15:0] IDX_FRM_SNAP_HI = 16'h8009;
  localparam logic [15:0] IDX_FRM_SNAP_LO = 16'h800a;
  localparam logic [15:0] IDX_LEN_SNAP = 16'h800b;
  localparam logic [15:0] IDX_ALGN_SNAP = 16'h800c;
  localparam logic [15:0] IDX_SYMB_SNAP = 16'h800d;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h8030;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h8031;

  // Field positions and reset values.
  localparam int BIT_CTRL = 0;
  localparam int BIT_RX_ERR_EVT = 0;
  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_IRQ_ENABLE = 1'b1;
  localparam logic RST_PATH_SELECT = 1'b0;
  localparam logic RST_IRQ_MASK = 1'b0;
  localparam logic [15:0] RST_CNT16 = 16'h0000;
  localparam logic [31:0] RST_CNT32 = 32'h0000_0000;

  // One observed data path: per-cycle symbol signals plus an end-of-frame strobe with status.
  typedef struct packed {
    logic dv;
    logic er;
    logic eof;
    logic len_err;
    logic algn_err;
    logic crc_err;
  } frame_in_s;

  // Whole state of the checker, bus slave included.
  typedef struct packed {
    logic path_sel;
    logic enable;
    logic irq_enable;
    logic irq_mask;
    logic irq_status;
    logic sym_seen;
    logic [15:0] err_count;
    logic [31:0] frm_cnt;
    logic [15:0] len_cnt;
    logic [15:0] algn_cnt;
    logic [15:0] sym_cnt;
    logic [31:0] snap_frm;
    logic [15:0] snap_len;
    logic [15:0] snap_algn;
    logic [15:0] snap_sym;
    logic wr_pend;
    logic [15:0] wr_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
  } fc_state_s;

  // Turns a byte address into a register index; returns all ones when unaligned or out of range.
  function automatic logic [15:0] addr_to_idx(input logic [31:0] addr);
    if (addr[1:0] != 2'b00 || addr[31:18] != 14'h0000) begin
      return 16'hffff;
    end
    return addr[17:2];
  endfunction

endpackage

// ---- hdl/frame_checker_counters.sv ----
// Frame checker statistics counters with an AHB-Lite register slave and one interrupt line.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module frame_checker_counters
  import fc_pkg::*;
#(
  parameter int ERR_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire frame_in_s rx_path,
  input wire frame_in_s tx_path,
  output logic irq
);

  // The registers are sixteen bits wide; wider counters would need another map.
  if (ERR_W != 16) begin : g_err_w_check
    $error("frame_checker_counters: ERR_W must be 16");
  end

  fc_state_s s_q;
  fc_state_s s_d;

  frame_in_s cur;
  logic addr_phase;
  logic rd_hit;
  logic rd_err_cnt;
  logic rd_status;
  logic [15:0] ap_idx;
  logic frame_done;
  logic sym_frame;
  logic rx_err_frame;
  logic [31:0] rd_val;

  // Pick the observed path and classify the frame that ends this cycle.
  always_comb begin
    cur = s_q.path_sel ? tx_path : rx_path;
    frame_done = s_q.enable && cur.eof;
    sym_frame = s_q.sym_seen || (cur.dv && cur.er);
    rx_err_frame = frame_done && (cur.crc_err || sym_frame);
  end

  // Address phase decode; transfers are zero wait state, so hready is always high here.
  always_comb begin
    addr_phase = hsel && htrans[1] && hready;
    ap_idx = addr_to_idx(haddr);
    rd_hit = addr_phase && !hwrite;
    rd_err_cnt = rd_hit && ap_idx == IDX_ERR_COUNT;
    rd_status = rd_hit && ap_idx == IDX_IRQ_STATUS;
  end

  // Read multiplexer; unmapped indices read as zero with an OKAY response.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (ap_idx)
      IDX_ENABLE: rd_val[BIT_CTRL] = s_q.enable;
      IDX_IRQ_ENABLE: rd_val[BIT_CTRL] = s_q.irq_enable;
      IDX_PATH_SELECT: rd_val[BIT_CTRL] = s_q.path_sel;
      IDX_ERR_COUNT: rd_val[15:0] = s_q.err_count;
      IDX_FRM_SNAP_HI: rd_val[15:0] = s_q.snap_frm[31:16];
      IDX_FRM_SNAP_LO: rd_val[15:0] = s_q.snap_frm[15:0];
      IDX_LEN_SNAP: rd_val[15:0] = s_q.snap_len;
      IDX_ALGN_SNAP: rd_val[15:0] = s_q.snap_algn;
      IDX_SYMB_SNAP: rd_val[15:0] = s_q.snap_sym;
      IDX_IRQ_STATUS: rd_val[BIT_RX_ERR_EVT] = s_q.irq_status;
      IDX_IRQ_MASK: rd_val[BIT_RX_ERR_EVT] = s_q.irq_mask;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Next-state logic for counters, snapshots, control bits and the bus slave.
  always_comb begin
    s_d = s_q;
    s_d.hreadyout = 1'b1;
    s_d.hresp = 1'b0;

    // The symbol flag lives for one frame; it is dropped at the frame end or when disabled.
    if (!s_q.enable || cur.eof) begin
      s_d.sym_seen = 1'b0;
    end else if (cur.dv && cur.er) begin
      s_d.sym_seen = 1'b1;
    end

    // live counters run regardless of snapshots
    if (frame_done) begin
      s_d.frm_cnt = s_q.frm_cnt + 32'h0000_0001;
    end
    if (frame_done && cur.len_err) begin
      s_d.len_cnt = s_q.len_cnt + 16'h0001;
    end
    if (frame_done && cur.algn_err) begin
      s_d.algn_cnt = s_q.algn_cnt + 16'h0001;
    end
    if (frame_done && sym_frame) begin
      s_d.sym_cnt = s_q.sym_cnt + 16'h0001;
    end

    // snapshot taken with the error read
    if (rd_err_cnt) begin
      s_d.snap_frm = s_q.frm_cnt;
      s_d.snap_len = s_q.len_cnt;
      s_d.snap_algn = s_q.algn_cnt;
      s_d.snap_sym = s_q.sym_cnt;
    end

    // clear on read, a new error wins
    if (rd_err_cnt) begin
      s_d.err_count = rx_err_frame ? 16'h0001 : RST_CNT16;
    end else if (rx_err_frame) begin
      s_d.err_count = s_q.err_count + 16'h0001;
    end

    if (rx_err_frame && s_q.irq_enable) begin
      s_d.irq_status = 1'b1;
    end else if (rd_status) begin
      s_d.irq_status = 1'b0;
    end

    // Read data is registered at the address phase edge so it stands in the data phase.
    if (rd_hit) begin
      s_d.hrdata = rd_val;
    end

    // Writes land one cycle late, when hwdata is valid.
    s_d.wr_pend = addr_phase && hwrite;
    s_d.wr_idx = ap_idx;
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        IDX_ENABLE: s_d.enable = hwdata[BIT_CTRL];
        IDX_IRQ_ENABLE: s_d.irq_enable = hwdata[BIT_CTRL];
        IDX_PATH_SELECT: s_d.path_sel = hwdata[BIT_CTRL];
        IDX_IRQ_MASK: s_d.irq_mask = hwdata[BIT_RX_ERR_EVT];
        default: s_d.wr_pend = s_d.wr_pend;
      endcase
    end

    // A level line: high while the unmasked event bit is set.
    s_d.irq = s_d.irq_status && s_d.irq_mask;
  end

  // State register; reset puts every counter and snapshot at zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{path_sel: RST_PATH_SELECT, enable: RST_ENABLE, irq_enable: RST_IRQ_ENABLE,
               irq_mask: RST_IRQ_MASK, irq_status: 1'b0, sym_seen: 1'b0,
               err_count: RST_CNT16, frm_cnt: RST_CNT32, len_cnt: RST_CNT16,
               algn_cnt: RST_CNT16, sym_cnt: RST_CNT16, snap_frm: RST_CNT32,
               snap_len: RST_CNT16, snap_algn: RST_CNT16, snap_sym: RST_CNT16,
               wr_pend: 1'b0, wr_idx: 16'h0000, hrdata: 32'h0000_0000,
               hreadyout: 1'b1, hresp: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Every output comes straight from the state register.
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hreadyout;
  assign hresp = s_q.hresp;
  assign irq = s_q.irq;

  // All checks run on the system clock and rest while reset is held.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // A read returns the error count and leaves zero behind.
  a_err_read_clears: assert property (
    rd_err_cnt && !rx_err_frame
      |=> s_q.err_count == 16'h0000 && hrdata[15:0] == $past(s_q.err_count))
    else $error("error counter not returned and cleared on read");

  // An error arriving with the read must not be lost by the clear.
  a_err_set_wins: assert property (
    rd_err_cnt && rx_err_frame |=> s_q.err_count == 16'h0001)
    else $error("error arriving with the read was lost");

  // Outside a read each error frame adds exactly one.
  a_err_count_step: assert property (
    !rd_err_cnt && rx_err_frame |=> s_q.err_count == $past(s_q.err_count) + 16'h0001)
    else $error("error counter did not step by one");

  // Without a read or an error frame the count stays put.
  a_err_count_hold: assert property (
    !rd_err_cnt && !rx_err_frame |=> $stable(s_q.err_count))
    else $error("error counter moved without cause");

  // The frame count is latched together with the error read.
  a_frame_snapshot: assert property (
    rd_err_cnt |=> {s_q.snap_frm[31:16], s_q.snap_frm[15:0]} == $past(s_q.frm_cnt))
    else $error("frame count snapshot does not match live count");

  // Snapshots move only on an error counter read, so a pair of reads stays consistent.
  a_snap_hold: assert property (
    !rd_err_cnt |=> $stable(s_q.snap_frm) && $stable(s_q.snap_len)
      && $stable(s_q.snap_algn) && $stable(s_q.snap_sym))
    else $error("snapshot changed without an error read");

  // The high snapshot register returns the upper half.
  a_high_half_read: assert property (
    rd_hit && ap_idx == IDX_FRM_SNAP_HI
      |=> hrdata == {16'h0000, $past(s_q.snap_frm[31:16])})
    else $error("high snapshot read returned wrong half");

  // The low snapshot register returns the lower half.
  a_low_half_read: assert property (
    rd_hit && ap_idx == IDX_FRM_SNAP_LO
      |=> hrdata == {16'h0000, $past(s_q.snap_frm[15:0])})
    else $error("low snapshot read returned wrong half");

  // The length error count is latched with the error read.
  a_len_snapshot: assert property (
    rd_err_cnt |=> s_q.snap_len == $past(s_q.len_cnt))
    else $error("length error snapshot wrong");

  // A checked frame with length error status steps the live count.
  a_len_counts: assert property (
    frame_done && cur.len_err |=> s_q.len_cnt == $past(s_q.len_cnt) + 16'h0001)
    else $error("length error frame not counted");

  // The alignment error count is latched with the error read.
  a_algn_snapshot: assert property (
    rd_err_cnt |=> s_q.snap_algn == $past(s_q.algn_cnt))
    else $error("alignment error snapshot wrong");

  // A checked frame with alignment error status steps the live count.
  a_algn_counts: assert property (
    frame_done && cur.algn_err |=> s_q.algn_cnt == $past(s_q.algn_cnt) + 16'h0001)
    else $error("alignment error frame not counted");

  // The symbol error count is latched with the error read.
  a_sym_snapshot: assert property (
    rd_err_cnt |=> s_q.snap_sym == $past(s_q.sym_cnt))
    else $error("symbol error snapshot wrong");

  // A frame that showed dv with er before its end is counted once at the end.
  a_symbol_count: assert property (
    s_q.enable && s_q.sym_seen && (s_q.path_sel ? tx_path.eof : rx_path.eof)
      |=> s_q.sym_cnt == $past(s_q.sym_cnt) + 16'h0001)
    else $error("symbol error frame not counted");

  // With the receive path selected, only its frame ends count.
  a_path_ignored: assert property (
    s_q.enable && !s_q.path_sel && !rx_path.eof |=> s_q.frm_cnt == $past(s_q.frm_cnt))
    else $error("frame on unselected path was counted");

  // With the transmit path selected, only its frame ends count.
  a_tx_path_ignored: assert property (
    s_q.enable && s_q.path_sel && !tx_path.eof |=> $stable(s_q.frm_cnt))
    else $error("frame on unselected receive path was counted");

  // A frame end on the selected receive path is counted.
  a_rx_selected_counts: assert property (
    s_q.enable && !s_q.path_sel && rx_path.eof |=> s_q.frm_cnt == $past(s_q.frm_cnt) + 32'h1)
    else $error("frame on selected receive path missed");

  // A frame end on the selected transmit path is counted.
  a_tx_selected_counts: assert property (
    s_q.enable && s_q.path_sel && tx_path.eof |=> s_q.frm_cnt == $past(s_q.frm_cnt) + 32'h1)
    else $error("frame on selected transmit path missed");

  // The select bit takes the data of its write.
  a_path_write: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_PATH_SELECT |=> s_q.path_sel == $past(hwdata[BIT_CTRL]))
    else $error("path select write did not land");

  // While disabled, frames and errors leave the live counts alone; a read may still clear.
  a_disabled_hold: assert property (
    !s_q.enable && !rd_err_cnt |=> $stable(s_q.frm_cnt) && $stable(s_q.err_count))
    else $error("counters moved while checker disabled");

  // While disabled, the error class counters stand still.
  a_disabled_counts: assert property (
    !s_q.enable |=> $stable(s_q.len_cnt) && $stable(s_q.algn_cnt) && $stable(s_q.sym_cnt))
    else $error("error class counter moved while disabled");

  // While disabled, no interrupt event is raised.
  a_disabled_irq: assert property (
    !s_q.enable && !s_q.irq_status |=> !s_q.irq_status)
    else $error("interrupt event raised while disabled");

  // The enable bit takes the data of its write.
  a_enable_write: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_ENABLE |=> s_q.enable == $past(hwdata[BIT_CTRL]))
    else $error("enable write did not land");

  // An enabled, unmasked receive error raises the line until the status read.
  a_irq_raise: assert property (
    rx_err_frame && s_q.irq_enable && s_q.irq_mask && !(s_q.wr_pend && s_q.wr_idx == IDX_IRQ_MASK)
      |=> irq ##1 (irq || $past(rd_status)))
    else $error("receive error did not raise the interrupt");

  // With the interrupt enable clear, an error sets no event.
  a_irq_gate_off: assert property (
    rx_err_frame && !s_q.irq_enable && !s_q.irq_status |=> !s_q.irq_status)
    else $error("event set although interrupt disabled");

  // The event bit stays until its register is read.
  a_status_sticky: assert property (
    s_q.irq_status && !rd_status |=> s_q.irq_status)
    else $error("interrupt event dropped without a read");

  // A status read clears the event unless a new one arrives with it.
  a_status_cleared: assert property (
    rd_status && !(rx_err_frame && s_q.irq_enable) |=> !s_q.irq_status)
    else $error("interrupt event not cleared by its read");

  // The live frame count advances on every checked frame.
  a_live_runs: assert property (
    frame_done |=> s_q.frm_cnt == $past(s_q.frm_cnt) + 32'h0000_0001)
    else $error("live frame count did not advance");

  // An error read never clears the live counters.
  a_live_not_cleared: assert property (
    rd_err_cnt && !frame_done |=> $stable(s_q.frm_cnt) && $stable(s_q.len_cnt))
    else $error("error read disturbed a live counter");

endmodule

// ---- tb/fc_frame_src.sv ----
// Behavioural source of frames on the two observed data paths.
`timescale 1ns/1ps
module fc_frame_src
  import fc_pkg::*;
(
  input wire logic mclk,
  output frame_in_s rx_path,
  output frame_in_s tx_path
);
  // Both paths rest with data valid low between frames.
  initial begin
    rx_path = '0;
    tx_path = '0;
  end

  // Drives one cycle on the chosen path, changing just after the edge.
  task automatic put(input logic tx, input frame_in_s f);
    @(posedge mclk);
    if (tx) begin
      tx_path <= f;
    end else begin
      rx_path <= f;
    end
  endtask

  // A two-cycle frame: data with optional symbol error, then the end strobe with status.
  // dv with er
  task automatic send(input logic tx, input logic er, input logic [2:0] st);
    put(tx, {1'b1, er, 1'b0, 3'h0});
    put(tx, {1'b1, 1'b0, 1'b1, st});
    put(tx, '0);
  endtask
endmodule

// ---- tb/tb_frame_checker_counters.sv ----
// Self-checking bench for the frame checker counters.
`timescale 1ns/1ps
module tb_frame_checker_counters
  import fc_pkg::*;
;
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, ef, el, ea, es;
  frame_in_s rx_path, tx_path;
  int failures, check_count, cycles;
  // Rows: {sel, tx, er, len, algn, crc} and {frm, len, algn, sym, rx_err} steps.
  logic [5:0] in_rows [6] = '{6'h00, 6'h0c, 6'h03, 6'h1f, 6'h3a, 6'h25};
  logic [4:0] out_rows [6] = '{5'h10, 5'h1b, 5'h15, 5'h00, 5'h17, 5'h00};

  frame_checker_counters #(.ERR_W(16)) i_frame_checker_counters (.mclk(mclk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_path(rx_path), .tx_path(tx_path), .irq(irq));
  fc_frame_src i_fc_frame_src (.mclk(mclk), .rx_path(rx_path), .tx_path(tx_path));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single-word transfer; waits on hready in both phases, read data taken at the end.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {14'h0000, idx, 2'b00};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // Reset values; snapshots are read before the error read, which then latches cleared counts.
  task automatic reset_vals();
    logic [15:0] idx [12] = '{IDX_ENABLE, IDX_IRQ_ENABLE, IDX_PATH_SELECT, IDX_FRM_SNAP_HI,
      IDX_FRM_SNAP_LO, IDX_LEN_SNAP, IDX_ALGN_SNAP, IDX_SYMB_SNAP, IDX_ERR_COUNT,
      IDX_IRQ_MASK, IDX_IRQ_STATUS, 16'h8002};
    for (int i = 0; i < 12; i++) begin
      rdchk(idx[i], (i < 2) ? 32'h1 : 32'h0);
    end
    rdchk(IDX_FRM_SNAP_LO, 32'h0);
    rdchk(IDX_SYMB_SNAP, 32'h0);
    check(irq, 32'h0);
    check({hresp, hreadyout}, 32'h1);
    ef = '0;
    el = '0;
    ea = '0;
    es = '0;
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: table of frames, then enable, read-only, interrupt and reset cases.
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    failures = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    reset_vals();
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, IDX_PATH_SELECT, {31'h0, in_rows[r][5]});
      i_fc_frame_src.send(in_rows[r][4], in_rows[r][3], in_rows[r][2:0]);
      ef += out_rows[r][4];
      el += out_rows[r][3];
      ea += out_rows[r][2];
      es += out_rows[r][1];
      rdchk(IDX_ERR_COUNT, {31'h0, out_rows[r][0]});
      rdchk(IDX_FRM_SNAP_HI, {16'h0, ef[31:16]});
      rdchk(IDX_FRM_SNAP_LO, {16'h0, ef[15:0]});
      rdchk(IDX_LEN_SNAP, el);
      rdchk(IDX_ALGN_SNAP, ea);
      rdchk(IDX_SYMB_SNAP, es);
    end
    bus(1'b1, IDX_ENABLE, 32'h0);
    i_fc_frame_src.send(1'b1, 1'b1, 3'h7);
    rdchk(IDX_ERR_COUNT, 32'h0);
    rdchk(IDX_FRM_SNAP_LO, ef);
    bus(1'b1, IDX_LEN_SNAP, 32'hffff);
    rdchk(IDX_LEN_SNAP, el);
    bus(1'b1, IDX_ENABLE, 32'h1);
    bus(1'b1, IDX_IRQ_MASK, 32'h1);
    i_fc_frame_src.send(1'b1, 1'b0, 3'h1);
    @(posedge mclk);
    check(irq, 32'h1);
    rdchk(IDX_IRQ_STATUS, 32'h1);
    check(irq, 32'h0);
    bus(1'b1, IDX_IRQ_ENABLE, 32'h0);
    i_fc_frame_src.send(1'b1, 1'b0, 3'h1);
    @(posedge mclk);
    check(irq, 32'h0);
    rdchk(IDX_IRQ_STATUS, 32'h0);
    rdchk(IDX_ERR_COUNT, 32'h2);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    reset_vals();
    results();
  end
endmodule
